// ==== hdl/crs_core_seq.sv ====
// register file, pointer pairs, stack pointer and interrupt sequencer
// assumes a decoder issues one command per instruction end and stalls
// while seq_busy_q is high; stack memory reads return one cycle later
//
// Notes on behaviour
// RL1: file offers 8/8, two 8 with 8, two 8 with 16, 16/16 port sets
// RL2: the 32 registers occupy data addresses 0 to 31
// RL3: top six registers form three pointers with displacement, inc, dec
// RL4: stack grows downward; pointer marks the current top
// RL5: push/pop move by one; call, entry, return move by two
// RL6: reset loads stack pointer with the last SRAM address
// RL7: stack pointer is readable and writable as two I/O bytes
// RL8: software sets the stack pointer before calls or enabling requests
// RL9: core runs straight from sys_clk, never divided
// RL10: fetch overlaps execution, one instruction per clock at best
// RL11: two-operand operation reads, computes and writes back in one clock
// RL12: service needs individual enable and global enable both set
// RL13: vectors at lowest addresses; lower index wins, reset first
// RL14: relocate bit moves vectors, boot fuse moves reset vector
// RL15: boot lock settings suppress requests by program counter region
// RL16: entry clears global enable; return sets it again
// RL17: vectoring clears the flag; writing one clears it too
// RL18: masked flags stay pending, then serve in priority order
// RL19: level requests count only while the condition holds
// RL20: one main instruction runs after a return before the next entry
// RL21: status register is neither saved on entry nor restored
// RL22: global disable takes effect at once, even for same-cycle requests
// RL23: global enable is bit 7 of the status register
// RL24: entry and return each take four clocks moving two stack bytes
// RL25: after global enable the next instruction runs before service
`timescale 1ns/10ps
`default_nettype none
module crs_core_seq (
	input wire logic sys_clk,
	input wire logic rstn,
	// register file ports
	input wire logic [4:0] rd_a_addr,
	input wire logic rd_a_wide,
	input wire logic [4:0] rd_b_addr,
	input wire logic wb_en,
	input wire logic wb_wide,
	input wire logic [4:0] wb_addr,
	input wire logic [15:0] wb_data,
	output logic [15:0] rd_a_q,
	output logic [7:0] rd_b_q,
	// data space access into the file
	input wire logic ds_rd,
	input wire logic ds_wr,
	input wire logic [15:0] ds_addr,
	input wire logic [7:0] ds_wdata,
	output logic [7:0] ds_rdata_q,
	// pointer addressing
	input wire logic ptr_go,
	input wire logic [1:0] ptr_sel,
	input wire logic [1:0] ptr_mode,
	input wire logic [5:0] ptr_disp,
	output logic [15:0] ptr_addr_q,
	// I/O port
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata_q,
	// instruction boundary and commands
	input wire logic instr_done,
	input wire logic [2:0] cmd,
	input wire logic [15:0] pc,
	input wire logic pc_in_boot,
	// stack memory
	input wire logic [7:0] stk_rdata,
	output logic stk_we_q,
	output logic stk_re_q,
	output logic [15:0] stk_addr_q,
	output logic [7:0] stk_wdata_q,
	output logic [15:0] stack_top_pointer_q,
	output logic [15:0] ret_pc_q,
	// interrupt sources and configuration
	input wire logic [7:0] flag_set,
	input wire logic [7:0] flag_clr,
	input wire logic [7:0] level_req,
	input wire logic [7:0] irq_en,
	input wire logic vector_relocate_bit,
	input wire logic boot_reset_fuse,
	input wire logic app_boot_lock_setting,
	input wire logic boot_section_lock_setting,
	output logic [7:0] flag_q,
	output logic irq_take_q,
	output logic [15:0] irq_vector_q,
	output logic [15:0] reset_vector_q,
	output logic seq_busy_q,
	output logic gie_q
);
	localparam int ENTRY_MIN = 4;
	localparam int ENTRY_MAX = 4;

	logic [7:0] rf_q [crs_pkg::RF_N];
	logic [15:0] sp_q, sp_d;
	logic [7:0] status_register_q;
	crs_pkg::crs_state_t st_q, st_d;
	logic [1:0] step_q;
	logic blk_q;

	// write port merge: write-back, then pointer update, then data space
	wire logic ds_hit = ({1'b0, ds_addr} < crs_pkg::RF_TOP);
	wire logic [4:0] ptr_lo = crs_pkg::PTR_BASE + {2'b00, ptr_sel, 1'b0};
	wire logic [15:0] ptr_val = {rf_q[ptr_lo + 5'h01], rf_q[ptr_lo]};
	wire logic [15:0] ptr_dec = ptr_val - crs_pkg::ONE16;
	wire logic [15:0] ptr_inc = ptr_val + crs_pkg::ONE16;
	wire logic ptr_upd = ptr_go && (ptr_mode == crs_pkg::PM_POSTINC ||
		ptr_mode == crs_pkg::PM_PREDEC);
	wire logic [15:0] ptr_eff = (ptr_mode == crs_pkg::PM_PREDEC) ? ptr_dec :
		(ptr_mode == crs_pkg::PM_DISP) ? ptr_val + {10'h000, ptr_disp} :
		ptr_val;
	wire logic [15:0] ptr_new = (ptr_mode == crs_pkg::PM_POSTINC) ?
		ptr_inc : ptr_dec;
	wire logic w_en = wb_en || ptr_upd || (ds_wr && ds_hit);
	wire logic w_wide = wb_en ? wb_wide : ptr_upd;
	wire logic [4:0] w_addr = wb_en ? wb_addr : ptr_upd ? ptr_lo :
		ds_addr[4:0];
	wire logic [15:0] w_data = wb_en ? wb_data : ptr_upd ? ptr_new :
		{8'h00, ds_wdata};

	// RL1: one write per entry
	// RL11: write lands at the same edge
	genvar gi;
	generate
		for (gi = 0; gi < crs_pkg::RF_N; gi++) begin : g_rf
			wire logic hit_lo = w_en && (w_addr == 5'(gi));
			wire logic hit_hi = w_en && w_wide &&
				(w_addr + 5'h01 == 5'(gi));
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn)
					rf_q[gi] <= 8'h00;
				else if (hit_lo)
					rf_q[gi] <= w_data[7:0];
				else if (hit_hi)
					rf_q[gi] <= w_data[15:8];
			end
		end
	endgenerate

	// RL1: read ports, 16-bit read takes the pair
	wire logic [15:0] rd_a_d = rd_a_wide ?
		{rf_q[rd_a_addr + 5'h01], rf_q[rd_a_addr]} :
		{8'h00, rf_q[rd_a_addr]};
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_a_q <= 16'h0000;
			rd_b_q <= 8'h00;
		end else begin
			rd_a_q <= rd_a_d;
			rd_b_q <= rf_q[rd_b_addr];
		end
	end

	// RL2: data space reads of low addresses hit the file
	// RL3: effective pointer address
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ds_rdata_q <= 8'h00;
			ptr_addr_q <= 16'h0000;
		end else begin
			if (ds_rd)
				ds_rdata_q <= ds_hit ? rf_q[ds_addr[4:0]] : 8'h00;
			if (ptr_go)
				ptr_addr_q <= ptr_eff;
		end
	end

	// request selection
	wire logic [7:0] pend = (flag_q | level_req) & irq_en;
	logic [2:0] win;
	always_comb begin
		win = 3'h0;
		// RL13: lowest index found last wins
		for (int k = crs_pkg::IRQ_N - 1; k >= 0; k--) begin
			if (pend[k])
				win = k[2:0];
		end
	end
	// RL15: lock settings block requests from the protected side
	wire logic lock_off = (app_boot_lock_setting && !pc_in_boot &&
		vector_relocate_bit) || (boot_section_lock_setting &&
		pc_in_boot && !vector_relocate_bit);
	// RL12: global and individual enables
	// RL22: a same-cycle disable blocks entry
	// RL20: blocked right after a return
	// RL25: enable acts through the registered bit, one boundary late
	wire logic take = (st_q == crs_pkg::ST_RUN) && instr_done &&
		gie_q && (|pend) && !blk_q && !lock_off &&
		(cmd != crs_pkg::CMD_CLI);
	wire logic [15:0] vec_base = vector_relocate_bit ?
		crs_pkg::BOOT_START : 16'h0000;
	wire logic [15:0] win_vec = vec_base +
		crs_pkg::VEC_STEP * ({13'h0000, win} + crs_pkg::ONE16);
	// RL10: a command is accepted on every ST_RUN clock without a take
	wire logic cmd_ok = (st_q == crs_pkg::ST_RUN) && !take;

	// RL17: flags, set wins over vectoring and write-one clear
	// RL18: flags persist while masked
	// RL19: level requests have no flag
	generate
		for (gi = 0; gi < crs_pkg::IRQ_N; gi++) begin : g_flag
			wire logic ack = take && (win == 3'(gi));
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn)
					flag_q[gi] <= 1'b0;
				else
					flag_q[gi] <= flag_set[gi] ||
						(flag_q[gi] && !flag_clr[gi] && !ack);
			end
		end
	endgenerate

	// sequencer state
	always_comb begin
		st_d = st_q;
		case (st_q)
			crs_pkg::ST_RUN: begin
				if (take)
					st_d = crs_pkg::ST_ENTRY;
				else if (cmd_ok && cmd == crs_pkg::CMD_RETURN_FROM_INTERRUPT)
					st_d = crs_pkg::ST_RETURN;
			end
			crs_pkg::ST_ENTRY, crs_pkg::ST_RETURN: begin
				if (step_q == crs_pkg::SEQ_CYC)
					st_d = crs_pkg::ST_RUN;
			end
			default: st_d = crs_pkg::ST_RUN;
		endcase
	end

	// RL4: stack pointer next value
	// RL5: moves by one or two
	always_comb begin
		sp_d = sp_q;
		if (st_q == crs_pkg::ST_ENTRY && step_q <= crs_pkg::STEP_HI)
			sp_d = sp_q - crs_pkg::ONE16;
		else if (st_q == crs_pkg::ST_RETURN && step_q <= crs_pkg::STEP_HI)
			sp_d = sp_q + crs_pkg::ONE16;
		else if (cmd_ok && cmd == crs_pkg::CMD_PUSH)
			sp_d = sp_q - crs_pkg::ONE16;
		else if (cmd_ok && cmd == crs_pkg::CMD_POP)
			sp_d = sp_q + crs_pkg::ONE16;
		else if (cmd_ok && cmd == crs_pkg::CMD_CALL)
			sp_d = sp_q - crs_pkg::TWO16;
		else if (cmd_ok && cmd == crs_pkg::CMD_RET)
			sp_d = sp_q + crs_pkg::TWO16;
		// RL7: I/O writes to the two bytes
		else if (io_wr && io_addr == crs_pkg::IO_SPL)
			sp_d = {sp_q[15:8], io_wdata};
		else if (io_wr && io_addr == crs_pkg::IO_SPH)
			sp_d = {io_wdata, sp_q[7:0]};
	end

	// RL6: reset value of the stack pointer
	// RL9: every register runs on undivided sys_clk
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sp_q <= crs_pkg::LAST_SRAM;
			st_q <= crs_pkg::ST_RUN;
			step_q <= 2'h0;
		end else begin
			sp_q <= sp_d;
			st_q <= st_d;
			step_q <= (st_q == crs_pkg::ST_RUN) ? 2'h0 : step_q + 2'h1;
		end
	end

	// RL16: entry clears, return end and enable command set
	// RL23: global enable is bit 7
	// RL21: status register is never pushed or popped
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			status_register_q <= crs_pkg::STATUS_REGISTER_RST;
		else if (take)
			status_register_q[crs_pkg::GIE_BIT] <= 1'b0;
		else if (st_q == crs_pkg::ST_RETURN && step_q == crs_pkg::SEQ_CYC)
			status_register_q[crs_pkg::GIE_BIT] <= 1'b1;
		else if (cmd_ok && cmd == crs_pkg::CMD_SEI)
			status_register_q[crs_pkg::GIE_BIT] <= 1'b1;
		else if (cmd_ok && cmd == crs_pkg::CMD_CLI)
			status_register_q[crs_pkg::GIE_BIT] <= 1'b0;
		else if (io_wr && io_addr == crs_pkg::IO_STATUS_REGISTER)
			status_register_q <= io_wdata;
	end
	assign gie_q = status_register_q[crs_pkg::GIE_BIT];

	// RL20: hold off one boundary after a return
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			blk_q <= 1'b0;
		else if (st_q == crs_pkg::ST_RETURN && step_q == crs_pkg::SEQ_CYC)
			blk_q <= 1'b1;
		else if (instr_done)
			blk_q <= 1'b0;
	end

	// RL24: stack traffic of the four-cycle sequences
	// RL13: vector of the winner, reset vector from the fuse
	// RL14: relocation of both vectors
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stk_we_q <= 1'b0;
			stk_re_q <= 1'b0;
			stk_addr_q <= 16'h0000;
			stk_wdata_q <= 8'h00;
			ret_pc_q <= 16'h0000;
			irq_take_q <= 1'b0;
			irq_vector_q <= 16'h0000;
			reset_vector_q <= 16'h0000;
			seq_busy_q <= 1'b0;
		end else begin
			irq_take_q <= take;
			seq_busy_q <= (st_d != crs_pkg::ST_RUN);
			reset_vector_q <= boot_reset_fuse ? crs_pkg::BOOT_START :
				16'h0000;
			if (take)
				irq_vector_q <= win_vec;
			stk_we_q <= (st_q == crs_pkg::ST_ENTRY) &&
				(step_q <= crs_pkg::STEP_HI);
			stk_re_q <= (st_q == crs_pkg::ST_RETURN) &&
				(step_q <= crs_pkg::STEP_HI);
			if (st_q == crs_pkg::ST_ENTRY)
				stk_addr_q <= sp_q;
			else if (st_q == crs_pkg::ST_RETURN)
				stk_addr_q <= sp_q + crs_pkg::ONE16;
			stk_wdata_q <= (step_q == crs_pkg::STEP_LO) ? pc[7:0] : pc[15:8];
			// read data lands a cycle after the strobe; high byte first
			if (st_q == crs_pkg::ST_RETURN && step_q == crs_pkg::STEP_CAP)
				ret_pc_q[15:8] <= stk_rdata;
			if (st_q == crs_pkg::ST_RETURN && step_q == crs_pkg::SEQ_CYC)
				ret_pc_q[7:0] <= stk_rdata;
		end
	end
	assign stack_top_pointer_q = sp_q;

	// RL7: I/O read-back
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			io_rdata_q <= 8'h00;
		else if (io_rd)
			io_rdata_q <= (io_addr == crs_pkg::IO_SPL) ? sp_q[7:0] :
				(io_addr == crs_pkg::IO_SPH) ? sp_q[15:8] :
				(io_addr == crs_pkg::IO_STATUS_REGISTER) ? status_register_q : 8'h00;
	end

	// checks
	sequence s_entry_run;
		irq_take_q ##0 seq_busy_q [*4];
	endsequence
	a_entry_clears_gie: assert property (@(posedge sys_clk) // RL16
		disable iff (!rstn) take |=> !gie_q) else $error("gie kept on entry");
	a_entry_four_cycles: assert property (@(posedge sys_clk) // RL24
		disable iff (!rstn) take |=> s_entry_run ##1 !seq_busy_q)
		else $error("entry length wrong");
	a_entry_sp_two: assert property (@(posedge sys_clk) // RL5
		disable iff (!rstn) take |-> ##ENTRY_MIN
		(sp_q == $past(sp_q, ENTRY_MAX) - crs_pkg::TWO16))
		else $error("entry moved stack wrong");
	a_push_sp_one: assert property (@(posedge sys_clk) // RL5
		disable iff (!rstn) cmd_ok && cmd == crs_pkg::CMD_PUSH |=>
		sp_q == $past(sp_q) - crs_pkg::ONE16) else $error("push step wrong");
	a_cli_blocks_take: assert property (@(posedge sys_clk) // RL22
		disable iff (!rstn) cmd == crs_pkg::CMD_CLI |=> !irq_take_q)
		else $error("entry after disable");
	a_take_needs_gie: assert property (@(posedge sys_clk) // RL12
		disable iff (!rstn) irq_take_q |-> $past(gie_q) &&
		$past(pend) != 8'h00) else $error("entry while masked");
	a_return_sets_gie: assert property (@(posedge sys_clk) // RL16
		disable iff (!rstn) st_q == crs_pkg::ST_RUN && cmd_ok &&
		cmd == crs_pkg::CMD_RETURN_FROM_INTERRUPT |=> ##ENTRY_MIN gie_q)
		else $error("return left gie clear");
	a_one_after_ret: assert property (@(posedge sys_clk) // RL20
		disable iff (!rstn) blk_q && instr_done |=> !irq_take_q)
		else $error("entry before one instruction");
	a_ack_clears_flag: assert property (@(posedge sys_clk) // RL17
		disable iff (!rstn) take && !flag_set[win] |=> !flag_q[$past(win)])
		else $error("flag kept after vectoring");
	a_sp_reset_top: assert property (@(posedge sys_clk) // RL6
		$rose(rstn) |-> sp_q == crs_pkg::LAST_SRAM)
		else $error("stack pointer reset wrong");
endmodule
`default_nettype wire

// ==== inc/crs_pkg.sv ====
// constants, commands and register map for the core sequencer block
// assumes one core clock and an external instruction decoder
package crs_pkg;
	localparam int RF_N = 32; // working registers
	localparam int RF_AW = 5;
	localparam int DW = 8;
	localparam int AW = 16;
	localparam int IRQ_N = 8; // peripheral request lines
	localparam int IRQ_IW = 3;
	// pointer pairs start here (low byte of each pair)
	localparam logic [4:0] PTR_BASE = 5'h1A;
	localparam logic [16:0] RF_TOP = 17'h00020; // data space end of file
	// I/O offsets
	localparam logic [5:0] IO_SPL = 6'h3D;
	localparam logic [5:0] IO_SPH = 6'h3E;
	localparam logic [5:0] IO_STATUS_REGISTER = 6'h3F;
	localparam int GIE_BIT = 7;
	localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;
	localparam logic [15:0] LAST_SRAM = 16'h08FF; // plain default
	localparam logic [15:0] BOOT_START = 16'h3800; // plain default
	localparam logic [15:0] VEC_STEP = 16'h0002;
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [15:0] TWO16 = 16'h0002;
	localparam logic [1:0] SEQ_CYC = 2'h3; // last step of a 4-cycle sequence
	localparam logic [1:0] STEP_LO = 2'h0;
	localparam logic [1:0] STEP_HI = 2'h1;
	localparam logic [1:0] STEP_CAP = 2'h2;
	typedef enum logic [2:0] {
		CMD_NONE, CMD_PUSH, CMD_POP, CMD_CALL, CMD_RET, CMD_RETURN_FROM_INTERRUPT, CMD_SEI,
		CMD_CLI
	} crs_cmd_t;
	typedef enum logic [1:0] {
		PM_PLAIN, PM_DISP, PM_POSTINC, PM_PREDEC
	} crs_pmode_t;
	typedef enum {ST_RUN, ST_ENTRY, ST_RETURN} crs_state_t;
endpackage

// ==== verif/cpu_regfile_stack_irq_seq_tb.sv ====
// self-checking bench for the core sequencer: file, stack and requests
// assumes the stack model answers reads one cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpu_regfile_stack_irq_seq_tb;
	typedef struct packed {
		logic [4:0] a;
		logic wide;
		logic [15:0] d;
		logic [15:0] exp;
	} crs_row_t;
	logic sys_clk = 1'h0, rstn = 1'h0, rd_a_wide = 1'h0, wb_en = 1'h0;
	logic wb_wide = 1'h0, ds_rd = 1'h0, ds_wr = 1'h0, ptr_go = 1'h0;
	logic io_rd = 1'h0, io_wr = 1'h0, instr_done = 1'h0, pc_in_boot = 1'h0;
	logic vector_relocate_bit = 1'h0, boot_reset_fuse = 1'h1;
	logic app_boot_lock_setting = 1'h0, boot_section_lock_setting = 1'h0;
	logic [4:0] rd_a_addr = 5'h00, rd_b_addr = 5'h00, wb_addr = 5'h00;
	logic [1:0] ptr_sel = 2'h0, ptr_mode = 2'h0;
	logic [5:0] ptr_disp = 6'h05, io_addr = 6'h00;
	logic [2:0] cmd = 3'h0;
	logic [7:0] ds_wdata = 8'h00, io_wdata = 8'h00, flag_set = 8'h00;
	logic [7:0] flag_clr = 8'h00, level_req = 8'h00, irq_en = 8'h00;
	logic [15:0] wb_data = 16'h0000, ds_addr = 16'h0000, pc = 16'h1234;
	logic [7:0] stk_rdata, rd_b_q, ds_rdata_q, io_rdata_q, stk_wdata_q;
	logic [7:0] flag_q;
	logic [15:0] rd_a_q, ptr_addr_q, stk_addr_q, stack_top_pointer_q;
	logic [15:0] ret_pc_q, irq_vector_q, reset_vector_q;
	logic stk_we_q, stk_re_q, irq_take_q, seq_busy_q, gie_q;
	int error_cnt = 0, checked = 0, ticks = 0;
	crs_row_t rows [4] = '{'{5'h03, 1'h0, 16'hFFA5, 16'h00A5},
		'{5'h0A, 1'h1, 16'h1234, 16'h1234}, '{5'h1A, 1'h1, 16'h0105, 16'h0105},
		'{5'h1F, 1'h0, 16'h3CFF, 16'h00FF}};
	logic [2:0] cl [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
	logic [15:0] spx [4] = '{16'h08EF, 16'h08F0, 16'h08EE, 16'h08F0};

	crs_core_seq dut (.sys_clk(sys_clk), .rstn(rstn), .rd_a_addr(rd_a_addr),
		.rd_a_wide(rd_a_wide), .rd_b_addr(rd_b_addr), .wb_en(wb_en),
		.wb_wide(wb_wide), .wb_addr(wb_addr), .wb_data(wb_data),
		.rd_a_q(rd_a_q), .rd_b_q(rd_b_q), .ds_rd(ds_rd), .ds_wr(ds_wr),
		.ds_addr(ds_addr), .ds_wdata(ds_wdata), .ds_rdata_q(ds_rdata_q),
		.ptr_go(ptr_go), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode),
		.ptr_disp(ptr_disp), .ptr_addr_q(ptr_addr_q), .io_rd(io_rd),
		.io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_rdata_q(io_rdata_q), .instr_done(instr_done), .cmd(cmd), .pc(pc),
		.pc_in_boot(pc_in_boot), .stk_rdata(stk_rdata), .stk_we_q(stk_we_q),
		.stk_re_q(stk_re_q), .stk_addr_q(stk_addr_q),
		.stk_wdata_q(stk_wdata_q), .stack_top_pointer_q(stack_top_pointer_q),
		.ret_pc_q(ret_pc_q), .flag_set(flag_set), .flag_clr(flag_clr),
		.level_req(level_req), .irq_en(irq_en),
		.vector_relocate_bit(vector_relocate_bit),
		.boot_reset_fuse(boot_reset_fuse),
		.app_boot_lock_setting(app_boot_lock_setting),
		.boot_section_lock_setting(boot_section_lock_setting),
		.flag_q(flag_q), .irq_take_q(irq_take_q), .irq_vector_q(irq_vector_q),
		.reset_vector_q(reset_vector_q), .seq_busy_q(seq_busy_q),
		.gie_q(gie_q));

	crs_stk_mem mem_i (.sys_clk(sys_clk), .stk_we(stk_we_q),
		.stk_re(stk_re_q), .stk_addr(stk_addr_q), .stk_wdata(stk_wdata_q),
		.stk_rdata(stk_rdata));

	// clock and hang guard
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		ticks++;
		if (ticks == 4000) begin
			error_cnt++;
			final_report();
		end
	end

	task automatic final_report();
		if (error_cnt == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic do_cmd(input logic [2:0] c);
		cmd = c;
		cyc(1);
		cmd = 3'h0;
		cyc(1);
	endtask

	// instruction boundary, optionally with a command in the same cycle
	task automatic bnd(input logic [2:0] c, input logic t);
		instr_done = 1'h1;
		cmd = c;
		cyc(1);
		instr_done = 1'h0;
		cmd = 3'h0;
		`CHK(irq_take_q, t)
		cyc(1);
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 20 && seq_busy_q !== 1'h0; i++)
			cyc(1);
	endtask

	task automatic ds_chk(input logic [15:0] a, input logic [7:0] e);
		ds_addr = a;
		ds_rd = 1'h1;
		cyc(1);
		ds_rd = 1'h0;
		`CHK(ds_rdata_q, e)
		cyc(1);
	endtask

	task automatic ptr_chk(input logic [1:0] m, input logic [15:0] ea, pr);
		ptr_mode = m;
		ptr_go = 1'h1;
		cyc(1);
		ptr_go = 1'h0;
		`CHK(ptr_addr_q, ea)
		cyc(2);
		`CHK(rd_a_q, pr)
	endtask

	task automatic io_op(input logic w, input logic [5:0] a, logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = w;
		io_rd = ~w;
		cyc(1);
		io_wr = 1'h0;
		io_rd = 1'h0;
		cyc(1);
	endtask

	// main sequence
	initial begin
		cyc(16);
		rstn = 1'h1;
		cyc(1);
		`CHK(stack_top_pointer_q, crs_pkg::LAST_SRAM)
		`CHK(reset_vector_q, crs_pkg::BOOT_START)
		`CHK(gie_q, 1'h0)
		foreach (rows[i]) begin
			wb_addr = rows[i].a;
			wb_wide = rows[i].wide;
			wb_data = rows[i].d;
			wb_en = 1'h1;
			cyc(1);
			wb_en = 1'h0;
			rd_a_addr = rows[i].a;
			rd_a_wide = rows[i].wide;
			cyc(1);
			`CHK(rd_a_q, rows[i].exp)
		end
		ds_chk(16'h0003, 8'hA5);
		ds_chk(16'h0020, 8'h00);
		ds_addr = 16'h000B;
		ds_wdata = 8'h77;
		ds_wr = 1'h1;
		rd_b_addr = 5'h0B;
		cyc(1);
		ds_wr = 1'h0;
		cyc(1);
		`CHK(rd_b_q, 8'h77)
		rd_a_addr = 5'h1A;
		rd_a_wide = 1'h1;
		ptr_chk(2'h2, 16'h0105, 16'h0106);
		ptr_chk(2'h3, 16'h0105, 16'h0105);
		ptr_chk(2'h1, 16'h010A, 16'h0105);
		io_op(1'h1, crs_pkg::IO_SPL, 8'hF0);
		io_op(1'h1, crs_pkg::IO_SPH, 8'h08);
		`CHK(stack_top_pointer_q, 16'h08F0)
		io_op(1'h0, crs_pkg::IO_SPH, 8'h00);
		`CHK(io_rdata_q, 8'h08)
		io_op(1'h0, 6'h10, 8'h00);
		`CHK(io_rdata_q, 8'h00)
		foreach (cl[i]) begin
			do_cmd(cl[i]);
			`CHK(stack_top_pointer_q, spx[i])
		end
		irq_en = 8'h24;
		flag_set = 8'h26;
		cyc(1);
		flag_set = 8'h00;
		`CHK(flag_q, 8'h26)
		bnd(crs_pkg::CMD_NONE, 1'h0);
		bnd(crs_pkg::CMD_SEI, 1'h0);
		bnd(crs_pkg::CMD_NONE, 1'h1);
		`CHK(irq_vector_q, 16'h0006)
		`CHK(gie_q, 1'h0)
		`CHK(flag_q, 8'h22)
		wait_idle();
		`CHK(stack_top_pointer_q, 16'h08EE)
		`CHK(mem_i.mem[16'h08F0], 8'h34)
		`CHK(mem_i.mem[16'h08EF], 8'h12)
		do_cmd(crs_pkg::CMD_RETURN_FROM_INTERRUPT);
		`CHK(seq_busy_q, 1'h1)
		wait_idle();
		`CHK(ret_pc_q, 16'h1234)
		`CHK(gie_q, 1'h1)
		`CHK(stack_top_pointer_q, 16'h08F0)
		vector_relocate_bit = 1'h1;
		pc = 16'h0ABC;
		bnd(crs_pkg::CMD_NONE, 1'h0);
		bnd(crs_pkg::CMD_NONE, 1'h1);
		`CHK(irq_vector_q, 16'h380C)
		wait_idle();
		do_cmd(crs_pkg::CMD_RETURN_FROM_INTERRUPT);
		wait_idle();
		`CHK(ret_pc_q, 16'h0ABC)
		bnd(crs_pkg::CMD_NONE, 1'h0);
		irq_en = 8'h02;
		bnd(crs_pkg::CMD_CLI, 1'h0);
		`CHK(gie_q, 1'h0)
		`CHK(flag_q, 8'h02)
		flag_clr = 8'h02;
		cyc(1);
		flag_clr = 8'h00;
		`CHK(flag_q, 8'h00)
		irq_en = 8'h08;
		level_req = 8'h08;
		cyc(1);
		level_req = 8'h00;
		bnd(crs_pkg::CMD_SEI, 1'h0);
		bnd(crs_pkg::CMD_NONE, 1'h0);
		level_req = 8'h08;
		app_boot_lock_setting = 1'h1;
		bnd(crs_pkg::CMD_NONE, 1'h0);
		app_boot_lock_setting = 1'h0;
		bnd(crs_pkg::CMD_NONE, 1'h1);
		`CHK(irq_vector_q, 16'h3808)
		level_req = 8'h00;
		wait_idle();
		final_report();
	end
endmodule
`default_nettype wire

// ==== verif/crs_stk_mem.sv ====
// stack SRAM model on the far side of the sequencer's stack port
// assumes one clock; read data follows the read strobe by one cycle
`timescale 1ns/10ps
`default_nettype none
module crs_stk_mem (
	input wire logic sys_clk,
	input wire logic stk_we,
	input wire logic stk_re,
	input wire logic [15:0] stk_addr,
	input wire logic [7:0] stk_wdata,
	output logic [7:0] stk_rdata
);
	logic [7:0] mem [0:65535];
	always @(posedge sys_clk) begin
		if (stk_we)
			mem[stk_addr] <= stk_wdata;
	end
	// late answer; toggles when idle so stale data never looks valid
	always @(posedge sys_clk) begin
		if (stk_re)
			stk_rdata <= mem[stk_addr];
		else
			stk_rdata <= ~stk_rdata;
	end
endmodule
`default_nettype wire
